// >>> hw/hbp_port.sv
// Host bus port: DMA master and register slave on a multiplexed address/data bus.
//
// Contract
// [RULE1] Address phase carries low address, then data
// [RULE2] Direction line driven steady only while master
// [RULE3] Slave: direction high outputs, low accepts data
// [RULE4] Master: sample on direction high, drive low
// [RULE5] Interrupt on any enabled flag when enabled
// [RULE6] Input enable only in read data phase
// [RULE7] Output enable in read address, whole write
// [RULE8] Data stable at data strobe rising edge
// [RULE9] Data strobe driven as master, input otherwise
// [RULE10] Release input ends burst after current transfer
// [RULE11] Release pin clear: mirrors companion bus-mode output
// [RULE12] Bus config bit selects mode/acknowledge pin functions
// [RULE13] Optional shortened five-clock DMA cycle
// [RULE14] Programmable burst length per bus ownership
// [RULE15] Config zero: request low while needed, held
// [RULE16] Config one: request only after pin high
// [RULE17] Arbiter removes grant only after request released
// [RULE18] Host port select chooses data or address port
// [RULE19] Interrupt released when flags clear or disabled
`timescale 1ns/1ps
module hbp_port (
	input  wire logic        CLOCK,
	input  wire logic        RST,
	// Avalon-MM register slave.
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	output logic             AVS_IRQ,
	// DMA work request from the protocol engine.
	input  wire logic        DMA_REQ,
	input  wire logic        DMA_WRITE,
	input  wire logic [15:0] DMA_ADDR,
	input  wire logic [15:0] DMA_WDATA,
	output logic      [15:0] DMA_RDATA,
	output logic             DMA_DONE,
	input  wire logic [4:0]  EVENT_SET,
	// Host bus pins.
	input  wire logic [15:0] BUS_DAL_I,
	output logic      [15:0] BUS_DAL_O,
	output logic             BUS_DAL_OE,
	input  wire logic        BUS_READ_I,
	output logic             BUS_READ_O,
	output logic             BUS_READ_OE,
	output logic             BUS_XCVR_IN_EN,
	output logic             BUS_XCVR_OUT_EN,
	output logic             BUS_XCVR_OE,
	input  wire logic        BUS_DAS_I,
	output logic             BUS_DAS_O,
	output logic             BUS_DAS_OE,
	input  wire logic        BUS_PIN15_I,
	output logic             BUS_PIN15_O,
	output logic             BUS_PIN15_OE,
	output logic             BUS_PIN16_O,
	output logic             BUS_PIN16_OE,
	output logic             BUS_REQ_O,
	output logic             BUS_REQ_OE,
	input  wire logic        BUS_GRANT_N,
	input  wire logic        BUS_READY_N,
	input  wire logic        BUS_CS_N,
	input  wire logic        BUS_PORT_SEL,
	output logic             BUS_ATTN_O,
	output logic             BUS_ATTN_OE
);
	typedef enum logic [2:0] {HBP_IDLE, HBP_REQ, HBP_ADDR, HBP_DATA, HBP_RELEASE} hbp_state_t;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [15:0] control_status_zero_ff;
	logic [15:0] control_status_four_ff;
	logic [7:0]  burst_len_ff;
	logic [15:0] reg_addr_ff;
	logic [4:0]  flags;
	logic        irq;
	logic        rd_pend_ff;
	logic        bus_wr;
	logic        bus_rd;
	logic        slave_wr_ff;
	logic [15:0] slave_data_ff;
	logic        das_d_ff;

	assign bus_wr = AVS_WRITE && AVS_BYTEENABLE[0] && AVS_BYTEENABLE[1];
	assign bus_rd = AVS_READ && !rd_pend_ff;
	assign AVS_WAITREQUEST = AVS_READ && !rd_pend_ff;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			control_status_zero_ff      <= hbp_pkg::CONTROL_STATUS_ZERO_RST;
			control_status_four_ff      <= hbp_pkg::CONTROL_STATUS_FOUR_RST;
			burst_len_ff <= hbp_pkg::BURST_RST;
		end else if (bus_wr) begin
			case (AVS_ADDRESS)
				hbp_pkg::OFF_CONTROL_STATUS_ZERO: control_status_zero_ff <= AVS_WRITEDATA[15:0] & 16'hFFE0;
				hbp_pkg::OFF_CONTROL_STATUS_FOUR: control_status_four_ff <= AVS_WRITEDATA[15:0];
				hbp_pkg::OFF_DMA:  burst_len_ff <= AVS_WRITEDATA[7:0]; // [RULE14]
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			rd_pend_ff   <= 1'b0;
			AVS_READDATA <= 32'h0000_0000;
		end else begin
			rd_pend_ff <= bus_rd;
			if (bus_rd) begin
				case (AVS_ADDRESS)
					hbp_pkg::OFF_CONTROL_STATUS_ZERO: AVS_READDATA <= {16'h0000, control_status_zero_ff[15:5], flags};
					hbp_pkg::OFF_CONTROL_STATUS_FOUR: AVS_READDATA <= {16'h0000, control_status_four_ff};
					hbp_pkg::OFF_DMA:  AVS_READDATA <= {24'h000000, burst_len_ff};
					hbp_pkg::OFF_ADDR: AVS_READDATA <= {16'h0000, reg_addr_ff};
					default:           AVS_READDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Interrupt flags
	// ----------------------------------------
	hbp_irq u_irq (
		.CLOCK    (CLOCK),
		.RST      (RST),
		.set_pulse(EVENT_SET),
		.clr_w1c  ((bus_wr && AVS_ADDRESS == hbp_pkg::OFF_CONTROL_STATUS_ZERO) ? AVS_WRITEDATA[4:0] : 5'h00),
		.mask     (control_status_zero_ff[15:11] | hbp_pkg::FLAG_MASK),
		.enable   (control_status_zero_ff[hbp_pkg::BIT_IRQ_EN]),
		.flags_ff (flags),
		.irq      (irq)
	);
	assign AVS_IRQ     = irq;
	assign BUS_ATTN_O  = 1'b0;
	assign BUS_ATTN_OE = irq; // [RULE5] [RULE19]

	// ----------------------------------------
	// DMA master
	// ----------------------------------------
	hbp_state_t  state_ff;
	logic [7:0]  xfer_cnt_ff;
	logic        is_write_ff;
	logic        req_prev_ff;
	logic        release_ff;
	logic [15:0] dal_o_ff;
	logic [15:0] rdata_ff;
	logic        das_o_ff;
	logic        done_ff;
	logic [3:0]  tcount;
	logic        tlast;
	logic        tload;
	logic        bus_config_bit;
	logic        relsel;
	logic        master;
	logic        data_hold;

	assign bus_config_bit      = control_status_four_ff[hbp_pkg::BIT_BUS_CONFIG_BIT]; // [RULE12]
	assign relsel    = control_status_four_ff[hbp_pkg::BIT_RELSEL];
	assign master    = (state_ff == HBP_ADDR) || (state_ff == HBP_DATA);
	assign tload     = (state_ff == HBP_REQ) && !BUS_GRANT_N;
	assign data_hold = (state_ff == HBP_DATA) && BUS_READY_N && tcount == hbp_pkg::ADDR_PHASE;

	hbp_cycle_timer u_timer (
		.CLOCK   (CLOCK),
		.RST     (RST),
		.load    (tload || ((state_ff == HBP_DATA) && tlast && !release_ff && DMA_REQ)),
		.length  (control_status_four_ff[hbp_pkg::BIT_SHORT] ? hbp_pkg::CYC_SHORT : hbp_pkg::CYC_NORMAL), // [RULE13]
		.hold    (data_hold),
		.count_ff(tcount),
		.last    (tlast)
	);

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state_ff    <= HBP_IDLE;
			xfer_cnt_ff <= 8'h00;
			is_write_ff <= 1'b0;
			release_ff  <= 1'b0;
			done_ff     <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (relsel && !BUS_PIN15_I && master)
				release_ff <= 1'b1; // [RULE10]
			case (state_ff)
				HBP_IDLE: begin
					release_ff <= 1'b0;
					if (DMA_REQ && BUS_GRANT_N && (!bus_config_bit || req_prev_ff)) // [RULE15] [RULE16]
						state_ff <= HBP_REQ;
				end
				HBP_REQ: begin
					is_write_ff <= DMA_WRITE;
					xfer_cnt_ff <= 8'h00;
					if (!BUS_GRANT_N)
						state_ff <= HBP_ADDR;
				end
				HBP_ADDR: begin
					state_ff <= HBP_DATA;
				end
				HBP_DATA: begin
					if (tlast) begin
						done_ff     <= 1'b1;
						xfer_cnt_ff <= xfer_cnt_ff + 8'h01;
						if (release_ff || !DMA_REQ || xfer_cnt_ff + 8'h01 >= burst_len_ff) // [RULE10] [RULE14]
							state_ff <= HBP_RELEASE;
						else begin
							is_write_ff <= DMA_WRITE;
							state_ff    <= HBP_ADDR;
						end
					end
				end
				HBP_RELEASE: begin
					state_ff <= HBP_IDLE; // [RULE17]
				end
				default: state_ff <= HBP_IDLE;
			endcase
		end
	end

	// Address then data on the shared lines; data strobe rises only after data has settled.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			dal_o_ff <= 16'h0000;
			das_o_ff <= 1'b1;
			rdata_ff <= 16'h0000;
		end else begin
			if (state_ff == HBP_REQ || (state_ff == HBP_DATA && tlast))
				dal_o_ff <= DMA_ADDR; // [RULE1]
			else if (state_ff == HBP_ADDR)
				dal_o_ff <= DMA_WDATA; // [RULE1]
			das_o_ff <= !(state_ff == HBP_DATA && !tlast); // [RULE8]
			if (state_ff == HBP_DATA && tlast && !is_write_ff)
				rdata_ff <= BUS_DAL_I; // [RULE4]
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			req_prev_ff <= 1'b1;
		else
			req_prev_ff <= BUS_REQ_O;
	end

	// ----------------------------------------
	// Slave access to the register ports
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			das_d_ff      <= 1'b1;
			slave_wr_ff   <= 1'b0;
			reg_addr_ff   <= 16'h0000;
			slave_data_ff <= 16'h0000;
		end else begin
			das_d_ff    <= BUS_DAS_I;
			slave_wr_ff <= 1'b0;
			if (!master && !BUS_CS_N && BUS_DAS_I && !das_d_ff && !BUS_READ_I) begin // [RULE3]
				if (BUS_PORT_SEL)
					reg_addr_ff <= BUS_DAL_I; // [RULE18]
				else
					slave_data_ff <= BUS_DAL_I;
			end
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	logic slave_out;
	assign slave_out = !master && !BUS_CS_N && BUS_READ_I; // [RULE3]

	assign BUS_DAL_O       = slave_out ? (BUS_PORT_SEL ? reg_addr_ff : slave_data_ff) : dal_o_ff;
	assign BUS_DAL_OE      = slave_out || (master && (state_ff == HBP_ADDR || is_write_ff)); // [RULE4]
	assign BUS_READ_O      = !is_write_ff; // [RULE2]
	assign BUS_READ_OE     = master; // [RULE2]
	assign BUS_XCVR_IN_EN  = (state_ff == HBP_DATA) && !is_write_ff; // [RULE6]
	assign BUS_XCVR_OUT_EN = (state_ff == HBP_ADDR) || is_write_ff; // [RULE7]
	assign BUS_XCVR_OE     = master; // [RULE7]
	assign BUS_DAS_O       = das_o_ff;
	assign BUS_DAS_OE      = master; // [RULE9]
	assign BUS_PIN16_O     = bus_config_bit ? !master : 1'b0; // [RULE12]
	assign BUS_PIN16_OE    = 1'b1;
	assign BUS_PIN15_O     = BUS_PIN16_O; // [RULE11]
	assign BUS_PIN15_OE    = !relsel; // [RULE10] [RULE11]
	assign BUS_REQ_O       = !(state_ff inside {HBP_REQ, HBP_ADDR, HBP_DATA}); // [RULE15] [RULE16]
	assign BUS_REQ_OE      = 1'b1;
	assign DMA_RDATA       = rdata_ff;
	assign DMA_DONE        = done_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_read_dir_tri : assert property (@(posedge CLOCK) disable iff (RST)
		!master |-> !BUS_READ_OE && !BUS_XCVR_OE) // [RULE2]
		else $error("direction driven while not master");
	a_read_dir_held : assert property (@(posedge CLOCK) disable iff (RST)
		(state_ff == HBP_ADDR) |=> $stable(BUS_READ_O)) // [RULE2]
		else $error("direction changed in a transfer");
	a_in_en_write : assert property (@(posedge CLOCK) disable iff (RST)
		(master && is_write_ff) |-> !BUS_XCVR_IN_EN) // [RULE6]
		else $error("input enable during write");
	a_out_en_addr : assert property (@(posedge CLOCK) disable iff (RST)
		(state_ff == HBP_ADDR) |-> BUS_XCVR_OUT_EN && BUS_DAL_OE) // [RULE7]
		else $error("address phase not driven");
	a_das_master : assert property (@(posedge CLOCK) disable iff (RST)
		BUS_DAS_OE == master) // [RULE9]
		else $error("strobe drive outside master");
	a_req_held : assert property (@(posedge CLOCK) disable iff (RST)
		(state_ff == HBP_ADDR) |-> !BUS_REQ_O ##1 !BUS_REQ_O) // [RULE15]
		else $error("request dropped mid transfer");
	a_burst_limit : assert property (@(posedge CLOCK) disable iff (RST)
		master |-> xfer_cnt_ff < burst_len_ff || burst_len_ff == 8'h00) // [RULE14]
		else $error("burst length exceeded");
	a_rel_pin_in : assert property (@(posedge CLOCK) disable iff (RST)
		relsel |-> !BUS_PIN15_OE) // [RULE10]
		else $error("release pin driven as input");
	a_dal_rd_data : assert property (@(posedge CLOCK) disable iff (RST)
		(state_ff == HBP_DATA && !is_write_ff) |-> !BUS_DAL_OE) // [RULE4]
		else $error("bus driven in read data phase");

	c_write_cycle : cover property (@(posedge CLOCK) master && is_write_ff ##1 done_ff);
	c_read_cycle  : cover property (@(posedge CLOCK) master && !is_write_ff ##1 done_ff);
	c_release     : cover property (@(posedge CLOCK) release_ff && state_ff == HBP_RELEASE);
	c_slave_write : cover property (@(posedge CLOCK) !BUS_CS_N && BUS_DAS_I && !das_d_ff);
endmodule

// >>> pkg/hbp_pkg.sv
// Package with register offsets, field positions, reset values and timing counts for the host bus port.
package hbp_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [3:0] OFF_CONTROL_STATUS_ZERO    = 4'h0;
	localparam logic [3:0] OFF_CONTROL_STATUS_FOUR    = 4'h4;
	localparam logic [3:0] OFF_DMA     = 4'h8;
	localparam logic [3:0] OFF_ADDR    = 4'hC;
	// ----------------------------------------
	// control_status_zero fields
	// ----------------------------------------
	localparam int         BIT_PRIM    = 0;
	localparam int         BIT_TXD     = 1;
	localparam int         BIT_RXD     = 2;
	localparam int         BIT_MEMORY_ERROR_FLAG    = 3;
	localparam int         BIT_LOST    = 4;
	localparam int         BIT_IRQ_EN  = 9;
	localparam int         BIT_START   = 15;
	localparam logic [4:0] FLAG_MASK   = 5'h1F;
	// ----------------------------------------
	// control_status_four fields
	// ----------------------------------------
	localparam int         BIT_BUS_CONFIG_BIT    = 0;
	localparam int         BIT_SHORT   = 2;
	localparam int         BIT_RELSEL  = 6;
	localparam logic [15:0] CONTROL_STATUS_ZERO_RST   = 16'h0000;
	localparam logic [15:0] CONTROL_STATUS_FOUR_RST   = 16'h0000;
	localparam logic [7:0]  BURST_RST  = 8'h08;
	// ----------------------------------------
	// Bus cycle timing in system clocks
	// ----------------------------------------
	localparam logic [3:0] CYC_NORMAL  = 4'h6;
	localparam logic [3:0] CYC_SHORT   = 4'h5;
	localparam logic [3:0] ADDR_PHASE  = 4'h2;
	localparam logic [7:0] READY_LIMIT = 8'hFF;
endpackage

// >>> hw/hbp_irq.sv
// Sticky event flags with write-one-to-clear and a masked level interrupt.
`timescale 1ns/1ps
module hbp_irq (
	input  wire logic       CLOCK,
	input  wire logic       RST,
	input  wire logic [4:0] set_pulse,
	input  wire logic [4:0] clr_w1c,
	input  wire logic [4:0] mask,
	input  wire logic       enable,
	output logic      [4:0] flags_ff,
	output logic            irq
);
	// A set in the same cycle as a clear wins so no event is lost.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			flags_ff <= 5'h00;
		end else begin
			flags_ff <= (flags_ff & ~clr_w1c) | set_pulse;
		end
	end

	assign irq = enable && ((flags_ff & mask) != 5'h00); // [RULE5] [RULE19]

	a_irq_follows : assert property (@(posedge CLOCK) disable iff (RST)
		(!enable || (flags_ff & mask) == 5'h00) |-> !irq) // [RULE19]
		else $error("interrupt high with nothing enabled");
	a_flag_sticky : assert property (@(posedge CLOCK) disable iff (RST)
		(flags_ff[0] && !clr_w1c[0]) |=> flags_ff[0]) // [RULE5]
		else $error("flag dropped without a clear");
endmodule

// >>> hw/hbp_cycle_timer.sv
// Down counter that times the phases of one DMA bus cycle.
`timescale 1ns/1ps
module hbp_cycle_timer (
	input  wire logic       CLOCK,
	input  wire logic       RST,
	input  wire logic       load,
	input  wire logic [3:0] length,
	input  wire logic       hold,
	output logic      [3:0] count_ff,
	output logic            last
);
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			count_ff <= 4'h0;
		end else if (load) begin
			count_ff <= length;
		end else if (!hold && count_ff != 4'h0) begin
			count_ff <= count_ff - 4'h1;
		end
	end

	assign last = (count_ff == 4'h1) && !hold;
endmodule

// >>> dv/hbp_host_model.sv
// Host side model: bus arbiter plus a small memory that answers DMA cycles.
`timescale 1ns/1ps
module hbp_host_model (
	input  wire logic        CLOCK,
	input  wire logic        RST,
	input  wire logic        BUS_REQ_O,
	input  wire logic        BUS_REQ_OE,
	input  wire logic [15:0] BUS_DAL_O,
	input  wire logic        BUS_DAL_OE,
	input  wire logic        BUS_READ_O,
	input  wire logic        BUS_DAS_O,
	input  wire logic        BUS_DAS_OE,
	input  wire logic [3:0]  WAIT_CYC,
	output logic             BUS_GRANT_N,
	output logic             BUS_READY_N,
	output logic      [15:0] BUS_DAL_I
);
	logic [15:0] mem [16];
	logic [15:0] addr_ff, dal_prev_ff, dal_prev2_ff;
	logic        das_prev_ff, rd_prev_ff, das_act;
	logic [3:0]  cnt_ff;
	initial for (int i = 0; i < 16; i++) mem[i] = {12'hC3A, 4'(i)};
	assign das_act = BUS_DAS_OE && !BUS_DAS_O;
	// Grant trails the request by one clock, so it is only withdrawn after the request is gone.
	always @(posedge CLOCK) begin
		BUS_GRANT_N <= RST || !(BUS_REQ_OE && !BUS_REQ_O);
	end
	// The address phase lies two clocks before the strobe is first seen low; write data is the last strobe-low value.
	always @(posedge CLOCK) begin
		dal_prev_ff <= BUS_DAL_O;
		dal_prev2_ff <= dal_prev_ff;
		das_prev_ff <= das_act;
		rd_prev_ff <= BUS_READ_O;
		cnt_ff <= (das_act && !RST) ? cnt_ff + 4'h1 : 4'h0;
		if (das_act && !das_prev_ff) addr_ff <= dal_prev2_ff;
		if (das_prev_ff && !das_act && !rd_prev_ff) mem[addr_ff[3:0]] <= dal_prev_ff;
	end
	assign BUS_READY_N = !(das_act && cnt_ff >= WAIT_CYC);
	// A released bus shows the complement of its last value, never a held copy.
	assign BUS_DAL_I = BUS_DAL_OE ? BUS_DAL_O : (das_act && BUS_READ_O) ? mem[addr_ff[3:0]] : ~dal_prev_ff;
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the host bus port against a host memory and arbiter model.
`timescale 1ns/1ps
module testbench;
	logic        CLOCK = 1'b0;
	logic        RST = 1'b1;
	logic [3:0]  AVS_ADDRESS = 4'h0;
	logic        AVS_READ = 1'b0;
	logic        AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [3:0]  AVS_BYTEENABLE = 4'hF;
	logic [31:0] AVS_READDATA, v;
	logic        AVS_WAITREQUEST, AVS_IRQ, DMA_DONE;
	logic        DMA_REQ = 1'b0;
	logic        DMA_WRITE = 1'b0;
	logic [15:0] DMA_ADDR = 16'h0;
	logic [15:0] DMA_WDATA = 16'h0;
	logic [15:0] DMA_RDATA, BUS_DAL_I, BUS_DAL_O;
	logic [4:0]  EVENT_SET = 5'h0;
	logic        BUS_DAL_OE, BUS_READ_O, BUS_READ_OE, BUS_XCVR_IN_EN, BUS_XCVR_OUT_EN, BUS_XCVR_OE;
	logic        BUS_DAS_O, BUS_DAS_OE, BUS_PIN15_O, BUS_PIN15_OE, BUS_PIN16_O, BUS_PIN16_OE;
	logic        BUS_REQ_O, BUS_REQ_OE, BUS_GRANT_N, BUS_READY_N, BUS_ATTN_O, BUS_ATTN_OE;
	logic        BUS_CS_N = 1'b1;
	logic        BUS_PORT_SEL = 1'b0;
	logic        rd_host = 1'b0;
	logic        das_host = 1'b1;
	logic        rel_in = 1'b1;
	logic [3:0]  WAIT_CYC = 4'h1;
	logic [1:0]  cs_hist = 2'b00;
	wire         BUS_READ_I, BUS_DAS_I, BUS_PIN15_I;
	int          bad_count = 0;
	int          check_count = 0;
	int          done_n, gap, g, n, k;
	int          cyc = 0;
	int          last_done = 0;
	// Shared pins resolve to the device level whenever the device enables its driver.
	assign BUS_READ_I = BUS_READ_OE ? BUS_READ_O : rd_host;
	assign BUS_DAS_I = BUS_DAS_OE ? BUS_DAS_O : das_host;
	assign BUS_PIN15_I = BUS_PIN15_OE ? BUS_PIN15_O : rel_in;
	hbp_port dut (.*);
	hbp_host_model host (.*);
	always #2 CLOCK = ~CLOCK;
	always @(posedge CLOCK) begin
		cyc++;
		if (DMA_DONE === 1'b1) begin
			done_n++;
			gap = cyc - last_done;
			last_done = cyc;
		end
	end
	// ----------------------------------------
	// Pin monitor
	// ----------------------------------------
	always @(negedge CLOCK) begin
		cs_hist = {cs_hist[0], BUS_CS_N};
		if (!RST && BUS_REQ_O === 1'b1 && BUS_GRANT_N === 1'b1 && cs_hist === 2'b11) begin
			chk("idle drive", {BUS_READ_OE, BUS_XCVR_OE, BUS_DAS_OE, BUS_DAL_OE}, 4'h0);
		end
		if (BUS_XCVR_OE === 1'b1 && BUS_READ_O === 1'b0) chk("in enable", BUS_XCVR_IN_EN, 1'b0);
		if (BUS_XCVR_OE === 1'b1 && BUS_DAS_O === 1'b0) begin
			chk("data phase", {BUS_READ_O, BUS_DAL_OE, BUS_XCVR_OUT_EN, BUS_XCVR_IN_EN}, DMA_WRITE ? 4'h6 : 4'h9);
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
		@(posedge CLOCK);
		AVS_WRITE <= 1'b1;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_BYTEENABLE <= be;
		do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
		AVS_WRITE <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge CLOCK);
		AVS_READ <= 1'b1;
		AVS_ADDRESS <= a;
		do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
		v = AVS_READDATA;
		AVS_READ <= 1'b0;
	endtask
	task wait_req(input logic lvl);
		for (k = 0; k < 300 && BUS_REQ_O !== lvl; k++) @(negedge CLOCK);
	endtask
	// A fresh request may already be under way when the engine drops its demand, so let it drain.
	task end_req;
		@(posedge CLOCK);
		DMA_REQ <= 1'b0;
		rel_in <= 1'b1;
		repeat (12) @(negedge CLOCK);
		wait_req(1'b1);
	endtask
	task dma(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(posedge CLOCK);
		DMA_REQ <= 1'b1;
		DMA_WRITE <= w;
		DMA_ADDR <= a;
		DMA_WDATA <= d;
		for (k = 0; k < 300 && DMA_DONE !== 1'b1; k++) @(negedge CLOCK);
		end_req;
	endtask
	task burst;
		@(posedge CLOCK);
		DMA_REQ <= 1'b1;
		DMA_WRITE <= 1'b1;
		done_n = 0;
		wait_req(1'b0);
		wait_req(1'b1);
		// The last done pulse is counted one clock after the request is released.
		@(negedge CLOCK);
		n = done_n;
		end_req;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		@(negedge CLOCK);
		chk("req idle", BUS_REQ_O, 1'b1);
		chk("irq idle", AVS_IRQ, 1'b0);
		rd(hbp_pkg::OFF_CONTROL_STATUS_ZERO);
		chk("control_status_zero reset", v, {16'h0, hbp_pkg::CONTROL_STATUS_ZERO_RST});
		rd(hbp_pkg::OFF_CONTROL_STATUS_FOUR);
		chk("control_status_four reset", v, {16'h0, hbp_pkg::CONTROL_STATUS_FOUR_RST});
		wr(hbp_pkg::OFF_DMA, 32'h3, 4'h1);
		rd(hbp_pkg::OFF_DMA);
		chk("burst reset", v, {24'h0, hbp_pkg::BURST_RST});
		rd(4'h2);
		chk("unmapped", v, 32'h0);
		$display("reset test done");
	endtask
	task t_irq;
		for (int i = 0; i < 5; i++) begin
			@(posedge CLOCK);
			EVENT_SET <= 5'h01 << i;
			@(posedge CLOCK);
			EVENT_SET <= 5'h00;
			repeat (2) @(negedge CLOCK);
			chk("irq masked", BUS_ATTN_OE, 1'b0);
			wr(hbp_pkg::OFF_CONTROL_STATUS_ZERO, 32'h200);
			repeat (2) @(negedge CLOCK);
			chk("irq on", {AVS_IRQ, BUS_ATTN_OE}, 2'h3);
			rd(hbp_pkg::OFF_CONTROL_STATUS_ZERO);
			chk("flag set", v, 32'h200 | (32'h1 << i));
			wr(hbp_pkg::OFF_CONTROL_STATUS_ZERO, (i % 2) ? 32'h0 : (32'h200 | (32'h1 << i)));
			repeat (2) @(negedge CLOCK);
			chk("irq off", {AVS_IRQ, BUS_ATTN_OE}, 2'h0);
			wr(hbp_pkg::OFF_CONTROL_STATUS_ZERO, 32'h1 << i);
		end
		$display("interrupt test done");
	endtask
	task t_slave;
		@(posedge CLOCK);
		BUS_CS_N <= 1'b0;
		BUS_PORT_SEL <= 1'b1;
		rd_host <= 1'b1;
		das_host <= 1'b0;
		repeat (2) @(negedge CLOCK);
		chk("slave out", {BUS_DAL_OE, BUS_DAS_OE}, 2'h2);
		@(posedge CLOCK);
		rd_host <= 1'b0;
		repeat (2) @(negedge CLOCK);
		chk("slave in", BUS_DAL_OE, 1'b0);
		@(posedge CLOCK);
		das_host <= 1'b1;
		@(posedge CLOCK);
		BUS_CS_N <= 1'b1;
		rd(hbp_pkg::OFF_ADDR);
		chk("addr port", v, 32'h0000FFFF);
		$display("slave test done");
	endtask
	task t_dma;
		wr(hbp_pkg::OFF_DMA, 32'h1);
		dma(1'b1, 16'hA5C3, 16'h1234);
		chk("addr phase", host.addr_ff, 16'hA5C3);
		chk("mem write", host.mem[3], 16'h1234);
		dma(1'b0, 16'h5A36, 16'h0);
		chk("read data", DMA_RDATA, 16'hC3A6);
		WAIT_CYC <= 4'h4;
		dma(1'b0, 16'h0009, 16'h0);
		chk("slow read", DMA_RDATA, 16'hC3A9);
		WAIT_CYC <= 4'h1;
		wr(hbp_pkg::OFF_CONTROL_STATUS_FOUR, 32'h1);
		dma(1'b1, 16'h0007, 16'hBEEF);
		chk("alt request", host.mem[7], 16'hBEEF);
		$display("dma test done");
	endtask
	task t_cycle;
		wr(hbp_pkg::OFF_CONTROL_STATUS_FOUR, 32'h0);
		wr(hbp_pkg::OFF_DMA, 32'h3);
		burst;
		g = gap;
		chk("burst count", n, 3);
		wr(hbp_pkg::OFF_CONTROL_STATUS_FOUR, 32'h4);
		burst;
		chk("short cycle", g - gap, 1);
		$display("cycle test done");
	endtask
	task t_release;
		wr(hbp_pkg::OFF_CONTROL_STATUS_FOUR, 32'h40);
		wr(hbp_pkg::OFF_DMA, 32'h8);
		chk("release input", BUS_PIN15_OE, 1'b0);
		@(posedge CLOCK);
		DMA_REQ <= 1'b1;
		done_n = 0;
		for (k = 0; k < 300 && done_n == 0; k++) @(negedge CLOCK);
		@(posedge CLOCK);
		rel_in <= 1'b0;
		wait_req(1'b1);
		chk("release stop", done_n <= 2, 1'b1);
		end_req;
		wr(hbp_pkg::OFF_CONTROL_STATUS_FOUR, 32'h0);
		repeat (2) @(negedge CLOCK);
		chk("mode pin", {BUS_PIN15_OE, BUS_PIN15_O}, {1'b1, BUS_PIN16_O});
		$display("release test done");
	endtask
	initial begin
		repeat (3) @(posedge CLOCK);
		RST <= 1'b0;
		t_reset;
		t_irq;
		t_slave;
		t_dma;
		t_cycle;
		t_release;
		stop_test;
	end
	// The tests need a few hundred clocks; this span leaves ample room before a hang is declared.
	initial begin
		repeat (20000) @(posedge CLOCK);
		bad_count++;
		stop_test;
	end
endmodule
